// *** rdo_top.sv ***
// resolver converter digital output ports: serial/parallel read port,
// encoder emulation, excitation select, start-up sequencing, pump clock
// assumes tracking words and fault levels arrive on the system clock;
// host pins are asynchronous and pass two flip-flops first
//
// Functional notes
// - data bus released; drive only while chip select and read strobe are low
// - read strobe falling edge starts a frame and loads the shift buffer
// - msb ready by first falling sclk; later bits shift on rising sclk edges
// - zeros follow the word on extra clock edges while strobe stays low
// - select high reads position, low reads velocity, set before strobe falls
// - encoder outputs run continuously while resolver inputs are valid
// - 1024 quadrature pulses per revolution
// - a leads b for increasing angle, b leads a when decreasing
// - direction high for increasing angle, low when decreasing, held while still (high after reset)
// - north marker while position passes zero, one quarter of a cycle
// - encoder updates at 4.096 MHz, four updates per pulse
// - two select pins choose 10, 12, 15 or 20 kHz excitation
// - select pins default high, giving 10 kHz when unconnected
// - reset clears position to zero and drives both fault flags low
// - first sample after settling releases flags and validates data
// - pump output is a 204.8 kHz square wave at half duty
// - word: data 15..4, select 3, degraded 2, tracking loss 1, parity 0
// - parity makes every word hold an odd number of ones
// - sample strobe falling edge copies tracking words into registers
// - serial mode: bit 11 output, bit 10 clock input, bits 0-9 released
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rdo_top #(
  parameter int unsigned P_SETTLE_CYC = rdo_pkg::SETTLE_CYC
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  // axi4-lite slave
  input  wire logic [7:0]  I_S_AXI_AWADDR,
  input  wire logic        I_S_AXI_AWVALID,
  output logic             O_S_AXI_AWREADY,
  input  wire logic [31:0] I_S_AXI_WDATA,
  input  wire logic [3:0]  I_S_AXI_WSTRB,
  input  wire logic        I_S_AXI_WVALID,
  output logic             O_S_AXI_WREADY,
  output logic [1:0]       O_S_AXI_BRESP,
  output logic             O_S_AXI_BVALID,
  input  wire logic        I_S_AXI_BREADY,
  input  wire logic [7:0]  I_S_AXI_ARADDR,
  input  wire logic        I_S_AXI_ARVALID,
  output logic             O_S_AXI_ARREADY,
  output logic [31:0]      O_S_AXI_RDATA,
  output logic [1:0]       O_S_AXI_RRESP,
  output logic             O_S_AXI_RVALID,
  input  wire logic        I_S_AXI_RREADY,
  // host pins
  input  wire logic [11:0] I_DB,
  output logic [11:0]      O_DB,
  output logic [11:0]      O_DB_OE,
  input  wire logic        I_RD_N,
  input  wire logic        I_CS_N,
  input  wire logic        I_POS_VEL_SELECT,
  input  wire logic        I_SAMPLE_N,
  input  wire logic        I_SERIAL_PORT_SELECT_N,
  input  wire logic        I_EXCITE_FREQ_SEL_HI,
  input  wire logic        I_EXCITE_FREQ_SEL_LO,
  // tracking loop and fault detection side
  input  wire logic [11:0] I_POS_TRACK,
  input  wire logic [11:0] I_VEL_TRACK,
  input  wire logic        I_FAULT_LOT,
  input  wire logic        I_FAULT_DOS,
  input  wire logic        I_INPUTS_VALID,
  // outputs
  output logic             O_ENC_A,
  output logic             O_ENC_B,
  output logic             O_NORTH_MARKER,
  output logic             O_DIR,
  output logic             O_TRACKING_LOSS_FLAG,
  output logic             O_SIGNAL_DEGRADED_FLAG,
  output logic             O_PUMP_SQUARE_OUT,
  output logic             O_EXCITATION_OUT
);

  typedef struct packed {
    rdo_pkg::rdo_pins_t  s1;
    rdo_pkg::rdo_pins_t  s2;
    rdo_pkg::rdo_pins_t  prev;
    rdo_pkg::rdo_phase_t ph;
    logic [23:0]         settle_cnt;
    logic [13:0]         upd_acc;
    logic                upd_tick;
    logic [16:0]         pump_acc;
    logic                pump;
    logic [8:0]          exc_cnt;
    logic                excitation_out;
    logic [11:0]         pos;
    logic [11:0]         vel;
    logic [11:0]         par_out;
    logic                tracking_loss_flag;
    logic                signal_degraded_flag;
    logic                enc_en;
    logic                aw_have;
    logic [7:0]          awaddr;
    logic                w_have;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } rdo_top_st_t;

  rdo_top_st_t q;
  rdo_top_st_t d;

  rdo_pkg::rdo_pins_t pins_in;
  rdo_pkg::rdo_enc_t  enc;
  logic [15:0]        word;
  logic [14:0]        word_hi;
  logic               shift_msb;
  logic               rd_fall;
  logic               sclk_rise;
  logic               sample_fall;
  logic               frame;
  logic               serial_mode;
  logic [8:0]         exc_half;
  logic [16:0]        pump_nxt;
  logic [13:0]        upd_nxt;

  // register decode, shared by read and write paths
  function automatic logic reg_hit(input logic [7:0] a);
    case ({a[7:2], 2'b00})
      rdo_pkg::REG_CTRL,
      rdo_pkg::REG_STATUS,
      rdo_pkg::REG_POS,
      rdo_pkg::REG_VEL: reg_hit = 1'b1;
      default:          reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [8:0] half_of(input logic hi, input logic lo);
    case ({hi, lo})
      2'b11:   half_of = rdo_pkg::EXC_HALF_11;
      2'b10:   half_of = rdo_pkg::EXC_HALF_10;
      2'b01:   half_of = rdo_pkg::EXC_HALF_01;
      default: half_of = rdo_pkg::EXC_HALF_00;
    endcase
  endfunction

  assign pins_in = '{
    rd_n:     I_RD_N,
    cs_n:     I_CS_N,
    sel:      I_POS_VEL_SELECT,
    sample_n: I_SAMPLE_N,
    sclk:     I_DB[rdo_pkg::DB_SCLK_BIT],
    soe_n:    I_SERIAL_PORT_SELECT_N,
    fs_hi:    I_EXCITE_FREQ_SEL_HI,
    fs_lo:    I_EXCITE_FREQ_SEL_LO
  };

  // edges seen on the second stage only
  assign rd_fall     = q.prev.rd_n & ~q.s2.rd_n;
  assign sclk_rise   = ~q.prev.sclk & q.s2.sclk;
  assign sample_fall = q.prev.sample_n & ~q.s2.sample_n;
  assign frame       = ~q.s2.cs_n & ~q.s2.rd_n;
  assign serial_mode = ~q.s2.soe_n;
  assign exc_half    = half_of(q.s2.fs_hi, q.s2.fs_lo);
  assign pump_nxt    = q.pump_acc + rdo_pkg::PUMP_STEP;
  assign upd_nxt     = q.upd_acc + rdo_pkg::UPD_STEP;

  // word built from the register chosen by the select level
  assign word_hi = {(q.s2.sel ? q.pos : q.vel), q.s2.sel, q.signal_degraded_flag, q.tracking_loss_flag};
  assign word    = {word_hi, ~(^word_hi)};

  always_comb
  begin
    d = q;
    d.s1   = pins_in;
    d.s2   = q.s1;
    d.prev = q.s2;

    // update enable: 4.096 MHz average from the 10 MHz clock
    if (upd_nxt >= rdo_pkg::UPD_MOD)
    begin
      d.upd_acc  = upd_nxt - rdo_pkg::UPD_MOD;
      d.upd_tick = 1'b1;
    end
    else
    begin
      d.upd_acc  = upd_nxt;
      d.upd_tick = 1'b0;
    end

    // pump toggles at twice its frequency; edges jitter by one cycle
    if (pump_nxt >= rdo_pkg::PUMP_MOD)
    begin
      d.pump_acc = pump_nxt - rdo_pkg::PUMP_MOD;
      d.pump     = ~q.pump;
    end
    else
    begin
      d.pump_acc = pump_nxt;
    end

    // excitation square, digital stand-in for the sine source
    if (q.exc_cnt >= exc_half - 9'h001)
    begin
      d.exc_cnt = 9'h000;
      d.excitation_out     = ~q.excitation_out;
    end
    else
    begin
      d.exc_cnt = q.exc_cnt + 9'h001;
    end

    if (sample_fall)
    begin
      d.pos = I_POS_TRACK;
      d.vel = I_VEL_TRACK;
    end

    // start-up: flags held low until sample after settling
    case (q.ph)
      rdo_pkg::PH_SETTLE:
      begin
        d.tracking_loss_flag = 1'b0;
        d.signal_degraded_flag = 1'b0;
        if (q.settle_cnt >= 24'(P_SETTLE_CYC - 1))
          d.ph = rdo_pkg::PH_WAIT;
        else
          d.settle_cnt = q.settle_cnt + 24'h000001;
      end
      rdo_pkg::PH_WAIT:
      begin
        if (sample_fall)
        begin
          d.ph  = rdo_pkg::PH_RUN;
          d.tracking_loss_flag = I_FAULT_LOT;
          d.signal_degraded_flag = I_FAULT_DOS;
        end
      end
      rdo_pkg::PH_RUN:
      begin
        d.tracking_loss_flag = I_FAULT_LOT;
        d.signal_degraded_flag = I_FAULT_DOS;
      end
      default:
      begin
        d.ph = rdo_pkg::PH_SETTLE;
      end
    endcase

    if (rd_fall && !q.s2.cs_n)
    begin
      d.par_out = q.s2.sel ? q.pos : q.vel;
    end

    // axi write: address and data taken in either order
    if (I_S_AXI_AWVALID && !q.aw_have)
    begin
      d.aw_have = 1'b1;
      d.awaddr  = I_S_AXI_AWADDR;
    end
    if (I_S_AXI_WVALID && !q.w_have)
    begin
      d.w_have = 1'b1;
      d.wdata  = I_S_AXI_WDATA;
      d.wstrb  = I_S_AXI_WSTRB;
    end
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = reg_hit(q.awaddr) ? rdo_pkg::RESP_OKAY : rdo_pkg::RESP_SLVERR;
      if ({q.awaddr[7:2], 2'b00} == rdo_pkg::REG_CTRL && q.wstrb[0])
        d.enc_en = q.wdata[rdo_pkg::CTRL_ENC_EN];
    end
    else if (q.bvalid && I_S_AXI_BREADY)
    begin
      d.bvalid = 1'b0;
    end

    // axi read: one outstanding, data one cycle after address
    if (I_S_AXI_ARVALID && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rresp  = reg_hit(I_S_AXI_ARADDR) ? rdo_pkg::RESP_OKAY : rdo_pkg::RESP_SLVERR;
      case ({I_S_AXI_ARADDR[7:2], 2'b00})
        rdo_pkg::REG_CTRL:   d.rdata = {31'h00000000, q.enc_en};
        rdo_pkg::REG_STATUS: d.rdata = {24'h000000, enc.dir, enc.nm, serial_mode,
                                        q.ph, I_INPUTS_VALID, q.signal_degraded_flag, q.tracking_loss_flag};
        rdo_pkg::REG_POS:    d.rdata = {20'h00000, q.pos};
        rdo_pkg::REG_VEL:    d.rdata = {20'h00000, q.vel};
        default:             d.rdata = 32'h00000000;
      endcase
    end
    else if (q.rvalid && I_S_AXI_RREADY)
    begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      q        <= '0;
      q.s1     <= rdo_pkg::PINS_RST;
      q.s2     <= rdo_pkg::PINS_RST;
      q.prev   <= rdo_pkg::PINS_RST;
      q.ph     <= rdo_pkg::PH_SETTLE;
      q.pos    <= rdo_pkg::POS_ZERO;
      q.vel    <= rdo_pkg::POS_ZERO;
      q.enc_en <= rdo_pkg::CTRL_ENC_EN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  rdo_shift u_shift (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_RST),
    .i_load  (rd_fall & ~q.s2.cs_n),
    .i_shift (sclk_rise & ~q.s2.rd_n),
    .i_word  (word),
    .o_msb   (shift_msb)
  );

  rdo_enc u_enc (
    .i_clk    (I_CLK_SYS),
    .i_rst    (I_RST),
    .i_tick   (q.upd_tick),
    .i_run    (I_INPUTS_VALID & q.enc_en),
    .i_target (I_POS_TRACK),
    .o_enc    (enc)
  );

  // serial mode keeps bits 0-9 released and bit 10 as an input
  always_comb
  begin
    O_DB    = serial_mode ? {shift_msb, 11'h000} : q.par_out;
    O_DB_OE = '0;
    if (serial_mode)
      O_DB_OE[rdo_pkg::DB_SO_BIT] = frame;
    else
      O_DB_OE = {12{frame}};
  end

  assign O_S_AXI_AWREADY        = ~q.aw_have;
  assign O_S_AXI_WREADY         = ~q.w_have;
  assign O_S_AXI_BVALID         = q.bvalid;
  assign O_S_AXI_BRESP          = q.bresp;
  assign O_S_AXI_ARREADY        = ~q.rvalid;
  assign O_S_AXI_RVALID         = q.rvalid;
  assign O_S_AXI_RDATA          = q.rdata;
  assign O_S_AXI_RRESP          = q.rresp;
  assign O_ENC_A                = enc.a;
  assign O_ENC_B                = enc.b;
  assign O_NORTH_MARKER         = enc.nm;
  assign O_DIR                  = enc.dir;
  assign O_TRACKING_LOSS_FLAG   = q.tracking_loss_flag;
  assign O_SIGNAL_DEGRADED_FLAG = q.signal_degraded_flag;
  assign O_PUMP_SQUARE_OUT      = q.pump;
  assign O_EXCITATION_OUT       = q.excitation_out;

endmodule

`default_nettype wire

// *** rdo_pkg.sv ***
// constants, field layouts and carrier types for the resolver output ports
// assumes a single 10 MHz system clock; shared by rdo_top, rdo_enc and the bench
`default_nettype none

package rdo_pkg;

  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned UPDATE_HZ   = 4_096_000;
  localparam int unsigned PUMP_HZ_X10 = 2_048_000;
  localparam int unsigned SETTLE_MS   = 20;
  localparam int unsigned SETTLE_CYC  = SETTLE_MS * (CLK_HZ / 1000);

  // fractional dividers: add step each cycle, wrap at modulus
  localparam logic [13:0] UPD_STEP  = 14'(UPDATE_HZ / 1000);
  localparam logic [13:0] UPD_MOD   = 14'(CLK_HZ / 1000);
  localparam logic [16:0] PUMP_STEP = 17'(2 * PUMP_HZ_X10 / 1000);
  localparam logic [16:0] PUMP_MOD  = 17'(CLK_HZ * 10 / 1000);

  // excitation frequencies in kHz and half periods in cycles
  localparam int unsigned EXC_KHZ_11 = 10;
  localparam int unsigned EXC_KHZ_10 = 12;
  localparam int unsigned EXC_KHZ_01 = 15;
  localparam int unsigned EXC_KHZ_00 = 20;
  localparam logic [8:0]  EXC_HALF_11 = 9'(CLK_HZ / (2000 * EXC_KHZ_11));
  localparam logic [8:0]  EXC_HALF_10 = 9'(CLK_HZ / (2000 * EXC_KHZ_10));
  localparam logic [8:0]  EXC_HALF_01 = 9'(CLK_HZ / (2000 * EXC_KHZ_01));
  localparam logic [8:0]  EXC_HALF_00 = 9'(CLK_HZ / (2000 * EXC_KHZ_00));

  // serial word layout
  localparam int unsigned W_DATA_LSB = 4;
  localparam int unsigned W_SEL      = 3;
  localparam int unsigned W_DOS      = 2;
  localparam int unsigned W_LOT      = 1;
  localparam int unsigned W_PAR      = 0;

  // data bus bits reused by the serial port
  localparam int unsigned DB_SO_BIT   = 11;
  localparam int unsigned DB_SCLK_BIT = 10;

  localparam logic [11:0] POS_ZERO = 12'h000;

  // register map
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_POS    = 8'h08;
  localparam logic [7:0]  REG_VEL    = 8'h0c;
  localparam int unsigned CTRL_ENC_EN = 0;
  localparam logic        CTRL_ENC_EN_RST = 1'b1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PH_SETTLE = 2'b00,
    PH_WAIT   = 2'b01,
    PH_RUN    = 2'b10
  } rdo_phase_t;

  typedef struct packed {
    logic rd_n;
    logic cs_n;
    logic sel;
    logic sample_n;
    logic sclk;
    logic soe_n;
    logic fs_hi;
    logic fs_lo;
  } rdo_pins_t;

  // frequency selects idle high as if pulled up
  localparam rdo_pins_t PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  typedef struct packed {
    logic a;
    logic b;
    logic nm;
    logic dir;
  } rdo_enc_t;

endpackage

`default_nettype wire

// *** rdo_shift.sv ***
// 16-bit serial output shifter, msb first, zero fill
// assumes load and shift are one-cycle pulses on the system clock
`timescale 1ns/1ps
`default_nettype none

module rdo_shift (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_load,
  input  wire logic        i_shift,
  input  wire logic [15:0] i_word,
  output logic             o_msb
);

  typedef struct packed {
    logic [15:0] sr;
  } rdo_shift_st_t;

  rdo_shift_st_t q;
  rdo_shift_st_t d;

  always_comb
  begin
    d = q;
    if (i_load)
    begin
      d.sr = i_word;
    end
    else if (i_shift)
    begin
      d.sr = {q.sr[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  assign o_msb = q.sr[15];

endmodule

`default_nettype wire

// *** rdo_enc.sv ***
// incremental encoder emulation: follows tracked angle one lsb per update
// assumes i_tick is a one-cycle enable at the update rate
`timescale 1ns/1ps
`default_nettype none

module rdo_enc (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_tick,
  input  wire logic        i_run,
  input  wire logic [11:0] i_target,
  output rdo_pkg::rdo_enc_t o_enc
);

  typedef struct packed {
    logic [11:0]       cnt;
    rdo_pkg::rdo_enc_t enc;
  } rdo_enc_st_t;

  rdo_enc_st_t q;
  rdo_enc_st_t d;
  logic [11:0] diff;

  // gray sequence, a leads b while counting up
  function automatic logic [1:0] quad(input logic [1:0] s);
    case (s)
      2'h0:    quad = 2'h0;
      2'h1:    quad = 2'h2;
      2'h2:    quad = 2'h3;
      default: quad = 2'h1;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    diff = i_target - q.cnt;
    if (i_tick && i_run && diff != rdo_pkg::POS_ZERO)
    begin
      // shortest way round the circle
      d.cnt = diff[11] ? q.cnt - 12'h001 : q.cnt + 12'h001;
      d.enc.dir = ~diff[11];
    end
    {d.enc.a, d.enc.b} = quad(d.cnt[1:0]);
    d.enc.nm = (d.cnt == rdo_pkg::POS_ZERO);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      q <= '{cnt: rdo_pkg::POS_ZERO, enc: '{1'b0, 1'b0, 1'b1, 1'b1}};
    else
      q <= d;
  end

  assign o_enc = q.enc;

endmodule

`default_nettype wire

// *** rdo_top_assertions.sv ***
// concurrent checks on rdo_top pins, bound into every rdo_top
// assumes synchronous active-high reset and host pins synchronised inside
`timescale 1ns/1ps
`default_nettype none

module rdo_top_assertions (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  input  wire logic        I_RD_N,
  input  wire logic        I_SERIAL_PORT_SELECT_N,
  input  wire logic [11:0] O_DB_OE,
  input  wire logic        O_ENC_A,
  input  wire logic        O_ENC_B,
  input  wire logic        O_NORTH_MARKER,
  input  wire logic        O_DIR,
  input  wire logic        O_TRACKING_LOSS_FLAG,
  input  wire logic        O_SIGNAL_DEGRADED_FLAG,
  input  wire logic        O_PUMP_SQUARE_OUT
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  // run length of the current pump level; first level after reset may run long
  logic [5:0] pump_run_q;
  logic       pump_q;
  always_ff @(posedge I_CLK_SYS)
  begin
    pump_q     <= O_PUMP_SQUARE_OUT;
    pump_run_q <= (I_RST || pump_q != O_PUMP_SQUARE_OUT) ? 6'h01 : pump_run_q + 6'h01;
  end

  // four samples cover the two-stage synchroniser
  sequence rd_idle_s;
    I_RD_N [*4];
  endsequence
  sequence serial_held_s;
    !I_SERIAL_PORT_SELECT_N [*4];
  endsequence

  bus_release_a: assert property (rd_idle_s |=> O_DB_OE == 12'h000)
    else $error("data bus enabled while read strobe high");
  serial_pins_a: assert property (serial_held_s |=> O_DB_OE[10:0] == 11'h000)
    else $error("serial mode enabled a bus bit other than 11");
  flags_reset_a: assert property (disable iff (1'b0)
    I_RST |=> !O_TRACKING_LOSS_FLAG && !O_SIGNAL_DEGRADED_FLAG)
    else $error("fault flags not low after reset");
  enc_reset_a: assert property (disable iff (1'b0)
    I_RST |=> {O_ENC_A, O_ENC_B, O_NORTH_MARKER} == 3'b001)
    else $error("encoder not at zero after reset");
  quad_step_a: assert property (!$stable({O_ENC_A, O_ENC_B})
    |-> $onehot({O_ENC_A ^ $past(O_ENC_A), O_ENC_B ^ $past(O_ENC_B)}))
    else $error("both quadrature channels moved at once");
  quad_rate_a: assert property (!$stable({O_ENC_A, O_ENC_B})
    |=> $stable({O_ENC_A, O_ENC_B}))
    else $error("quadrature stepped on consecutive cycles");
  dir_phase_a: assert property (!$stable({O_ENC_A, O_ENC_B})
    |-> O_DIR == (O_ENC_A != $past(O_ENC_B)))
    else $error("direction does not match quadrature order");
  nm_zero_a: assert property (O_NORTH_MARKER |-> !O_ENC_A && !O_ENC_B)
    else $error("north marker outside the zero quarter");
  pump_half_a: assert property (O_PUMP_SQUARE_OUT != pump_q
    |-> pump_run_q inside {[6'd24:6'd26]})
    else $error("pump half period out of range");
endmodule

bind rdo_top rdo_top_assertions i_rdo_top_assertions (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_RD_N(I_RD_N),
  .I_SERIAL_PORT_SELECT_N(I_SERIAL_PORT_SELECT_N), .O_DB_OE(O_DB_OE),
  .O_ENC_A(O_ENC_A), .O_ENC_B(O_ENC_B), .O_NORTH_MARKER(O_NORTH_MARKER), .O_DIR(O_DIR),
  .O_TRACKING_LOSS_FLAG(O_TRACKING_LOSS_FLAG),
  .O_SIGNAL_DEGRADED_FLAG(O_SIGNAL_DEGRADED_FLAG), .O_PUMP_SQUARE_OUT(O_PUMP_SQUARE_OUT)
);

`default_nettype wire

// *** rdo_host_model.sv ***
// host serial reader: frames the read strobe and serial clock, samples data
// assumes the 100 ns system clock; serial clock rests high between frames
`timescale 1ns/1ps
`default_nettype none

module rdo_host_model (
  input  wire logic i_clk,
  input  wire logic i_so,
  output logic      o_rd_n,
  output logic      o_sclk
);
  localparam int NB = 20;

  initial
  begin
    o_rd_n = 1'b1;
    o_sclk = 1'b1;
  end

  // 500 ns high, 300 ns low: 800 ns period, data taken at each falling edge
  task automatic frame(output logic [NB-1:0] w);
    w = '0;
    @(posedge i_clk);
    o_rd_n <= 1'b0;
    for (int i = 0; i < NB; i++)
    begin
      repeat (5) @(posedge i_clk);
      w = {w[NB-2:0], i_so};
      o_sclk <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    o_rd_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

// *** rdo_top_test.sv ***
// self-checking bench for rdo_top: registers, serial frames, encoder, excitation
// assumes rdo_host_model plays the host; pins change by nba on the rising edge
`timescale 1ns/1ps
`default_nettype none

module rdo_top_test;
  localparam int unsigned SETTLE = 50;
  logic        clk, rst, awv, wv, brdy, arv, rrdy, tgl;
  logic        cs_n, sel, smp_n, soe_n, fs_hi, fs_lo, tracking_loss_flag, signal_degraded_flag, vld;
  logic        awr, wr, bv, arr, rv, a, b, nm, dir, lotf, dosf, pump, excitation_out, rd_n, sclk;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [11:0] pos, vel, db_o, db_oe;
  logic [1:0]  br, rr;
  int          n_errors, checked, n_a;
  logic [11:0] tp [3] = '{12'h001, 12'h000, 12'hffe};
  logic [3:0]  te [3] = '{4'b1001, 4'b0010, 4'b1100};
  logic [8:0]  hx [4] = '{rdo_pkg::EXC_HALF_00, rdo_pkg::EXC_HALF_01,
                          rdo_pkg::EXC_HALF_10, rdo_pkg::EXC_HALF_11};
  // an undriven bus bit toggles so it never reads as the last value
  wire         so_w = db_oe[11] ? db_o[11] : tgl;

  rdo_top #(.P_SETTLE_CYC(SETTLE)) i_rdo_top (
    .I_CLK_SYS(clk), .I_RST(rst),
    .I_S_AXI_AWADDR(awa), .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awr),
    .I_S_AXI_WDATA(wd), .I_S_AXI_WSTRB(4'hf), .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wr),
    .O_S_AXI_BRESP(br), .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(brdy),
    .I_S_AXI_ARADDR(ara), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arr),
    .O_S_AXI_RDATA(rdat), .O_S_AXI_RRESP(rr), .O_S_AXI_RVALID(rv), .I_S_AXI_RREADY(rrdy),
    .I_DB({so_w, sclk, {10{tgl}}}), .O_DB(db_o), .O_DB_OE(db_oe),
    .I_RD_N(rd_n), .I_CS_N(cs_n), .I_POS_VEL_SELECT(sel), .I_SAMPLE_N(smp_n),
    .I_SERIAL_PORT_SELECT_N(soe_n), .I_EXCITE_FREQ_SEL_HI(fs_hi),
    .I_EXCITE_FREQ_SEL_LO(fs_lo), .I_POS_TRACK(pos), .I_VEL_TRACK(vel),
    .I_FAULT_LOT(tracking_loss_flag), .I_FAULT_DOS(signal_degraded_flag), .I_INPUTS_VALID(vld),
    .O_ENC_A(a), .O_ENC_B(b), .O_NORTH_MARKER(nm), .O_DIR(dir),
    .O_TRACKING_LOSS_FLAG(lotf), .O_SIGNAL_DEGRADED_FLAG(dosf),
    .O_PUMP_SQUARE_OUT(pump), .O_EXCITATION_OUT(excitation_out)
  );

  rdo_host_model i_rdo_host_model (.i_clk(clk), .i_so(so_w), .o_rd_n(rd_n), .o_sclk(sclk));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) tgl <= ~tgl;
  always @(posedge a) n_a++;

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm_s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm_s, exp, seen);
    end
  endtask

  task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    awa <= ad;
    wd <= d;
    {awv, wv, brdy} <= 3'b111;
    fork
      begin
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 1'b0;
      end
      begin
        do @(posedge clk); while (wr !== 1'b1);
        wv <= 1'b0;
      end
    join
    do @(posedge clk); while (bv !== 1'b1);
    brdy <= 1'b0;
    check("bresp", {30'h0, br}, {30'h0, er});
    // let an edge pass so the next call never re-raises bready in this step
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    ara <= ad;
    {arv, rrdy} <= 2'b11;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rrdy <= 1'b0;
    check("rdata", rdat, ed);
    check("rresp", {30'h0, rr}, {30'h0, er});
    @(posedge clk);
  endtask

  function automatic logic [19:0] sword(input logic [11:0] d, input logic s);
    logic [14:0] r;
    r = {d, s, 1'b0, 1'b1};
    return {r, ~^r, 4'h0};
  endfunction

  initial
  begin
    #5_000_000;
    n_errors++;
    complete_run;
  end

  initial
  begin
    logic [19:0] w, e;
    int n;
    logic p;
    {awv, wv, brdy, arv, rrdy, tgl, tracking_loss_flag, signal_degraded_flag, soe_n} = '0;
    {rst, cs_n, smp_n, fs_hi, fs_lo, sel, vld} = '1;
    {awa, ara, wd, pos, vel} = '0;
    {n_errors, checked, n_a} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("encoder reset", {a, b, nm}, 3'b001);
    check("flags reset", {lotf, dosf}, 2'b00);
    axr(rdo_pkg::REG_POS, 32'h0, rdo_pkg::RESP_OKAY);
    axr(8'h10, 32'h0, rdo_pkg::RESP_SLVERR);
    axr(rdo_pkg::REG_STATUS, 32'he4, rdo_pkg::RESP_OKAY);
    axw(rdo_pkg::REG_CTRL, 32'h1, rdo_pkg::RESP_OKAY);
    axw(8'h10, 32'h1, rdo_pkg::RESP_SLVERR);
    {pos, vel, tracking_loss_flag, signal_degraded_flag} <= {12'ha5c, 12'h3f0, 2'b11};
    repeat (SETTLE + 10) @(posedge clk);
    check("flags settle", {lotf, dosf}, 2'b00);
    smp_n <= 1'b0;
    repeat (8) @(posedge clk);
    {smp_n, signal_degraded_flag, pos} <= {2'b10, 12'h000};
    repeat (6) @(posedge clk);
    check("flags run", {lotf, dosf}, 2'b10);
    axr(rdo_pkg::REG_POS, 32'ha5c, rdo_pkg::RESP_OKAY);
    axr(rdo_pkg::REG_VEL, 32'h3f0, rdo_pkg::RESP_OKAY);
    for (int s = 1; s >= 0; s--)
    begin
      sel <= s[0];
      repeat (4) @(posedge clk);
      i_rdo_host_model.frame(w);
      e = sword(s[0] ? 12'ha5c : 12'h3f0, s[0]);
      check("serial word", {12'h0, w}, {12'h0, e});
    end
    // parallel mode first, then serial with chip select high and low
    for (int c = 2; c >= 0; c--)
    begin
      {soe_n, cs_n} <= {c == 2, c == 1};
      fork
        i_rdo_host_model.frame(w);
        begin
          repeat (20) @(posedge clk);
          check("bus enable", {20'h0, db_oe},
                c == 2 ? 32'hfff : (c == 1 ? 32'h0 : 32'h800));
          if (c == 2)
            check("parallel word", {20'h0, db_o}, 32'h3f0);
        end
      join
    end
    repeat (3000) @(posedge clk);
    for (int k = 0; k < 3; k++)
    begin
      pos <= tp[k];
      repeat (12) @(posedge clk);
      check("encoder", {a, b, nm, dir}, te[k]);
    end
    // invalid resolver inputs freeze the emulation
    vld <= 1'b0;
    pos <= 12'h000;
    repeat (12) @(posedge clk);
    check("encoder hold", {a, b, nm, dir}, 4'b1100);
    vld <= 1'b1;
    n = n_a;
    for (int q = 1; q <= 4; q++)
    begin
      pos <= 12'(q * 1024 - 2);
      repeat (2700) @(posedge clk);
    end
    check("pulses per turn", n_a - n, 32'd1024);
    for (int f = 3; f >= 0; f--)
    begin
      {fs_hi, fs_lo} <= f[1:0];
      repeat (1100) @(posedge clk);
      p = excitation_out;
      do @(posedge clk); while (excitation_out === p);
      p = excitation_out;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (excitation_out === p);
      check("excitation half", n, {23'h0, hx[f]});
    end
    complete_run;
  end
endmodule

`default_nettype wire
